// ### rtl/ssc_drive.sv
`timescale 1ns/1ps
module ssc_drive
  import ssc_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  // Link
  ssc_link_if.drive link,
  // Digital inputs
  input wire logic digital_input_one,
  input wire logic digital_input_three,
  input wire logic din_func_assigned,
  // Status
  output logic [7:0] active_station,
  output logic [15:0] active_rate_code,
  output logic active_chain,
  output logic drive_enable,
  output logic op_mode_sel,
  output logic pkt_dropped
);
  import ssc_pkg::*;

  ssc_rx_e rx_st_r, rx_st_nxt;
  logic [10:0] rx_cyc_r, rx_cyc_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  ssc_pkt_t rx_buf_r, rx_buf_nxt;
  logic [3:0] rx_cnt_r, rx_cnt_nxt;
  logic pkt_in_r, pkt_in_nxt;

  ssc_tx_e tx_st_r, tx_st_nxt;
  logic [10:0] tx_cyc_r, tx_cyc_nxt;
  logic [2:0] tx_bit_r, tx_bit_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [19:0][7:0] txq_r, txq_nxt;
  logic [4:0] tx_len_r, tx_len_nxt;
  logic [4:0] tx_idx_r, tx_idx_nxt;
  logic txd_r, txd_nxt;
  logic drop_r, drop_nxt;

  logic [7:0] station_r, station_nxt, st_station_r, st_station_nxt, act_station_r, act_station_nxt;
  logic [15:0] rate_r, rate_nxt, st_rate_r, st_rate_nxt, act_rate_r, act_rate_nxt;
  logic chain_r, chain_nxt, st_chain_r, st_chain_nxt, act_chain_r, act_chain_nxt;
  logic loading_r, loading_nxt;
  logic den_r, den_nxt, mode_r, mode_nxt;

  logic [10:0] div;
  logic accept;
  logic [23:0] key;
  logic [7:0] cmd;
  logic [31:0] wdata, rdata;
  logic [7:0] res;
  logic is_wr, known;
  ssc_pkt_t reply;

  assign div = bit_cycles(act_rate_r);

  // Receiver
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_cyc_nxt = rx_cyc_r - 11'h001;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_buf_nxt = rx_buf_r;
    rx_cnt_nxt = rx_cnt_r;
    pkt_in_nxt = 1'b0;
    unique case (rx_st_r)
      RX_IDLE: begin
        rx_cyc_nxt = {1'b0, div[10:1]};
        // receiver held off while settings load
        if (!loading_r && !link.h2d) begin
          rx_st_nxt = RX_START;
        end
      end
      RX_START: if (rx_cyc_r == 11'h000) begin
        rx_cyc_nxt = div - 11'h001;
        rx_bit_nxt = 3'h0;
        rx_st_nxt = link.h2d ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (rx_cyc_r == 11'h000) begin
        rx_cyc_nxt = div - 11'h001;
        rx_sh_nxt = {link.h2d, rx_sh_r[7:1]};
        rx_bit_nxt = rx_bit_r + 3'h1;
        if (rx_bit_r == LAST_BIT) begin
          rx_st_nxt = RX_STOP;
        end
      end
      RX_STOP: if (rx_cyc_r == 11'h000) begin
        rx_st_nxt = RX_IDLE;
        if (link.h2d) begin
          rx_buf_nxt[rx_cnt_r] = rx_sh_r;
          rx_cnt_nxt = (rx_cnt_r == PKT_LAST) ? 4'h0 : rx_cnt_r + 4'h1;
          pkt_in_nxt = (rx_cnt_r == PKT_LAST);
        end else begin
          rx_cnt_nxt = 4'h0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_r <= RX_IDLE;
      rx_cyc_r <= 11'h000;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_buf_r <= '0;
      rx_cnt_r <= 4'h0;
      pkt_in_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_cyc_r <= rx_cyc_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_buf_r <= rx_buf_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      pkt_in_r <= pkt_in_nxt;
    end
  end

  // Object access decode; values are raw internal units, no scaling
  always_comb begin
    key = {rx_buf_r[3], rx_buf_r[2], rx_buf_r[4]};
    cmd = rx_buf_r[1];
    wdata = {rx_buf_r[8], rx_buf_r[7], rx_buf_r[6], rx_buf_r[5]};
    // act only on own station with good checksum
    accept = pkt_in_r && rx_buf_r[0] == act_station_r && pkt_csum(rx_buf_r) == rx_buf_r[9];
    is_wr = (cmd == CMD_WR4) || (cmd == CMD_WR2) || (cmd == CMD_WR1);
    known = 1'b1;
    rdata = 32'h00000000;
    res = RES_RD1;
    // objects addressed by index and subindex
    unique case (key)
      OBJ_STATION[31:8]: rdata = {24'h000000, station_r};
      OBJ_RATE[31:8]: begin
        rdata = {16'h0000, rate_r};
        res = RES_RD2;
      end
      OBJ_SAVE[31:8]: rdata = {24'h000000, SAVE_DEF};
      OBJ_CHAIN[31:8]: rdata = {31'h00000000, chain_r};
      default: known = 1'b0;
    endcase
    if (!is_wr && cmd != CMD_RD) begin
      res = RES_ERR;
      rdata = ERR_BAD_CMD;
    end else if (!known) begin
      res = RES_ERR;
      rdata = ERR_NO_OBJ;
    end else if (is_wr) begin
      res = RES_WR_OK;
      rdata = wdata;
    end
    reply = {8'h00, rdata, rx_buf_r[4], rx_buf_r[3], rx_buf_r[2], res, act_station_r};
    reply[9] = pkt_csum(reply);
  end

  // Configuration objects: working, stored and applied copies
  always_comb begin
    station_nxt = station_r;
    rate_nxt = rate_r;
    chain_nxt = chain_r;
    st_station_nxt = st_station_r;
    st_rate_nxt = st_rate_r;
    st_chain_nxt = st_chain_r;
    act_station_nxt = act_station_r;
    act_rate_nxt = act_rate_r;
    act_chain_nxt = act_chain_r;
    loading_nxt = restart;
    // applied copies change only on restart load
    if (loading_r) begin
      act_station_nxt = st_station_r;
      act_rate_nxt = st_rate_r;
      act_chain_nxt = st_chain_r;
    end
    if (accept && is_wr && known) begin
      unique case (key)
        OBJ_STATION[31:8]: station_nxt = wdata[7:0];
        OBJ_RATE[31:8]: rate_nxt = wdata[15:0];
        OBJ_CHAIN[31:8]: chain_nxt = wdata[0];
        default: begin
          if (wdata[7:0] == SAVE_STORE) begin
            st_station_nxt = station_r;
            st_rate_nxt = rate_r;
            st_chain_nxt = chain_r;
          end else if (wdata[7:0] == SAVE_INIT) begin
            station_nxt = STATION_DEF;
            rate_nxt = RATE_DEF;
            chain_nxt = CHAIN_DEF;
          end
        end
      endcase
    end
    // inputs steer the drive only while assigned
    den_nxt = din_func_assigned & digital_input_one;
    mode_nxt = din_func_assigned & digital_input_three;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      station_r <= STATION_DEF;
      rate_r <= RATE_DEF;
      chain_r <= CHAIN_DEF;
      st_station_r <= STATION_DEF;
      st_rate_r <= RATE_DEF;
      st_chain_r <= CHAIN_DEF;
      act_station_r <= STATION_DEF;
      act_rate_r <= RATE_DEF;
      act_chain_r <= CHAIN_DEF;
      loading_r <= 1'b1;
      den_r <= 1'b0;
      mode_r <= 1'b0;
    end else begin
      station_r <= station_nxt;
      rate_r <= rate_nxt;
      chain_r <= chain_nxt;
      st_station_r <= st_station_nxt;
      st_rate_r <= st_rate_nxt;
      st_chain_r <= st_chain_nxt;
      act_station_r <= act_station_nxt;
      act_rate_r <= act_rate_nxt;
      act_chain_r <= act_chain_nxt;
      loading_r <= loading_nxt;
      den_r <= den_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Transmitter; a packet arriving while a reply is still going out is dropped
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_cyc_nxt = tx_cyc_r - 11'h001;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    txq_nxt = txq_r;
    tx_len_nxt = tx_len_r;
    tx_idx_nxt = tx_idx_r;
    txd_nxt = txd_r;
    drop_nxt = accept && tx_len_r != 5'h00;
    if (accept && tx_len_r == 5'h00) begin
      // chained mode echoes host packet first
      if (act_chain_r) begin
        txq_nxt = {reply, rx_buf_r};
        tx_len_nxt = CHAIN_BYTES;
      end else begin
        txq_nxt = {80'h0, reply};
        tx_len_nxt = PKT_BYTES;
      end
    end
    unique case (tx_st_r)
      TX_IDLE: if (tx_len_r != 5'h00) begin
        tx_st_nxt = TX_START;
        tx_cyc_nxt = div - 11'h001;
        tx_sh_nxt = txq_r[tx_idx_r];
        txd_nxt = 1'b0;
      end
      TX_START: if (tx_cyc_r == 11'h000) begin
        tx_st_nxt = TX_DATA;
        tx_cyc_nxt = div - 11'h001;
        tx_bit_nxt = 3'h0;
        txd_nxt = tx_sh_r[0];
      end
      // eight data bits then one stop bit
      TX_DATA: if (tx_cyc_r == 11'h000) begin
        tx_cyc_nxt = div - 11'h001;
        tx_bit_nxt = tx_bit_r + 3'h1;
        tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
        txd_nxt = tx_sh_r[1];
        if (tx_bit_r == LAST_BIT) begin
          tx_st_nxt = TX_STOP;
          txd_nxt = 1'b1;
        end
      end
      TX_STOP: if (tx_cyc_r == 11'h000) begin
        tx_st_nxt = TX_IDLE;
        tx_idx_nxt = tx_idx_r + 5'h01;
        if (tx_idx_r + 5'h01 == tx_len_r) begin
          tx_idx_nxt = 5'h00;
          tx_len_nxt = 5'h00;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_r <= TX_IDLE;
      tx_cyc_r <= 11'h000;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      txq_r <= '0;
      tx_len_r <= 5'h00;
      tx_idx_r <= 5'h00;
      txd_r <= 1'b1;
      drop_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_cyc_r <= tx_cyc_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      txq_r <= txq_nxt;
      tx_len_r <= tx_len_nxt;
      tx_idx_r <= tx_idx_nxt;
      txd_r <= txd_nxt;
      drop_r <= drop_nxt;
    end
  end

  assign link.d2h = txd_r;
  assign active_station = act_station_r;
  assign active_rate_code = act_rate_r;
  assign active_chain = act_chain_r;
  assign drive_enable = den_r;
  assign op_mode_sel = mode_r;
  assign pkt_dropped = drop_r;
endmodule

// ### rtl/ssc_pkg.sv
package ssc_pkg;
  localparam int CLK_HZ = 25_000_000;
  // Fixed 8N1 framing, ten-byte packets
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] PKT_LAST = 4'h9;
  localparam logic [4:0] PKT_BYTES = 5'h0A;
  localparam logic [4:0] CHAIN_BYTES = 5'h14;
  // Rate codes and the line rates they select
  localparam logic [15:0] RATE_19200 = 16'h021C;
  localparam logic [15:0] RATE_38400 = 16'h010E;
  localparam logic [15:0] RATE_115200 = 16'h005A;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_115200 = 115200;
  // Defaults
  localparam logic [15:0] RATE_DEF = RATE_38400;
  localparam logic [7:0] STATION_DEF = 8'h01;
  localparam logic CHAIN_DEF = 1'b0;
  localparam logic [7:0] SAVE_DEF = 8'h00;
  localparam logic [7:0] SAVE_STORE = 8'h01;
  localparam logic [7:0] SAVE_INIT = 8'h0A;
  // Object keys: index, subindex (top 24 bits of the printed address)
  localparam logic [31:0] OBJ_STATION = 32'h100B0008;
  localparam logic [31:0] OBJ_RATE = 32'h2FE00010;
  localparam logic [31:0] OBJ_SAVE = 32'h2FF00108;
  localparam logic [31:0] OBJ_CHAIN = 32'h65100B08;
  // Payload command and reply codes
  localparam logic [7:0] CMD_WR4 = 8'h23;
  localparam logic [7:0] CMD_WR2 = 8'h2B;
  localparam logic [7:0] CMD_WR1 = 8'h2F;
  localparam logic [7:0] CMD_RD = 8'h40;
  localparam logic [7:0] RES_WR_OK = 8'h60;
  localparam logic [7:0] RES_RD4 = 8'h43;
  localparam logic [7:0] RES_RD2 = 8'h4B;
  localparam logic [7:0] RES_RD1 = 8'h4F;
  localparam logic [7:0] RES_ERR = 8'h80;
  localparam logic [31:0] ERR_NO_OBJ = 32'h06020000;
  localparam logic [31:0] ERR_BAD_CMD = 32'h05040001;
  // Host reply timeout
  localparam int RSP_TIMEOUT_US = 100_000;

  typedef logic [9:0][7:0] ssc_pkt_t;
  typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100,
                            RX_STOP = 4'b1000} ssc_rx_e;
  typedef enum logic [3:0] {TX_IDLE = 4'b0001, TX_START = 4'b0010, TX_DATA = 4'b0100,
                            TX_STOP = 4'b1000} ssc_tx_e;

  // Clock cycles per bit for a rate code; unknown codes fall back to the default rate
  function automatic logic [10:0] bit_cycles(input logic [15:0] code);
    int baud;
    baud = (code == RATE_19200) ? BAUD_19200 : (code == RATE_115200) ? BAUD_115200 : BAUD_38400;
    return 11'(CLK_HZ / baud);
  endfunction

  // Negated sum of bytes 0..8, low byte
  function automatic logic [7:0] pkt_csum(input ssc_pkt_t p);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 9; i++) begin
      s = s + p[i];
    end
    return 8'(-s);
  endfunction
endpackage

// ### rtl/ssc_link_if.sv
`timescale 1ns/1ps
interface ssc_link_if;
  // Idle-high serial lines, host to drive and drive to host
  logic h2d;
  logic d2h;
  modport drive (input h2d, output d2h);
  modport host (output h2d, input d2h);
endinterface

// ### rtl/ssc_host.sv
`timescale 1ns/1ps
module ssc_host
  import ssc_pkg::*;
#(
  parameter int RSP_TIMEOUT_CYC = RSP_TIMEOUT_US * (CLK_HZ / 1_000_000)
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Link
  ssc_link_if.host link,
  // Link settings, must match the drives
  input wire logic [15:0] rate_code,
  input wire logic chain_mode,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_station,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_index,
  input wire logic [7:0] cmd_sub,
  input wire logic [31:0] cmd_data,
  // Response
  output logic rsp_valid,
  output logic [7:0] rsp_code,
  output logic [31:0] rsp_data,
  output logic rsp_timeout
);
  import ssc_pkg::*;
  typedef enum logic [2:0] {H_IDLE = 3'b001, H_SEND = 3'b010, H_WAIT = 3'b100} ssc_host_e;

  ssc_host_e h_st_r, h_st_nxt;
  ssc_rx_e rx_st_r, rx_st_nxt;
  ssc_tx_e tx_st_r, tx_st_nxt;
  logic [10:0] rx_cyc_r, rx_cyc_nxt, tx_cyc_r, tx_cyc_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt, tx_bit_r, tx_bit_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt, tx_sh_r, tx_sh_nxt;
  ssc_pkt_t rx_buf_r, rx_buf_nxt, txq_r, txq_nxt;
  logic [3:0] rx_cnt_r, rx_cnt_nxt, tx_idx_r, tx_idx_nxt;
  logic pkt_in_r, pkt_in_nxt, skip_r, skip_nxt, txd_r, txd_nxt;
  logic [7:0] stn_r, stn_nxt;
  logic [31:0] tmo_r, tmo_nxt;
  logic rdy_r, rdy_nxt, vld_r, vld_nxt, tmo_err_r, tmo_err_nxt;
  logic [7:0] code_r, code_nxt;
  logic [31:0] data_r, data_nxt;
  logic [10:0] div;
  logic good;

  assign div = bit_cycles(rate_code);
  assign good = pkt_in_r && rx_buf_r[0] == stn_r && pkt_csum(rx_buf_r) == rx_buf_r[9];

  always_comb begin
    h_st_nxt = h_st_r;
    rx_st_nxt = rx_st_r;
    rx_cyc_nxt = rx_cyc_r - 11'h001;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_buf_nxt = rx_buf_r;
    rx_cnt_nxt = rx_cnt_r;
    pkt_in_nxt = 1'b0;
    tx_st_nxt = tx_st_r;
    tx_cyc_nxt = tx_cyc_r - 11'h001;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    txq_nxt = txq_r;
    tx_idx_nxt = tx_idx_r;
    txd_nxt = txd_r;
    skip_nxt = skip_r;
    stn_nxt = stn_r;
    tmo_nxt = tmo_r;
    rdy_nxt = rdy_r;
    vld_nxt = 1'b0;
    tmo_err_nxt = tmo_err_r;
    code_nxt = code_r;
    data_nxt = data_r;
    unique case (rx_st_r)
      RX_IDLE: begin
        rx_cyc_nxt = {1'b0, div[10:1]};
        if (!link.d2h) begin
          rx_st_nxt = RX_START;
        end
      end
      RX_START: if (rx_cyc_r == 11'h000) begin
        rx_cyc_nxt = div - 11'h001;
        rx_bit_nxt = 3'h0;
        rx_st_nxt = link.d2h ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (rx_cyc_r == 11'h000) begin
        rx_cyc_nxt = div - 11'h001;
        rx_sh_nxt = {link.d2h, rx_sh_r[7:1]};
        rx_bit_nxt = rx_bit_r + 3'h1;
        if (rx_bit_r == LAST_BIT) begin
          rx_st_nxt = RX_STOP;
        end
      end
      RX_STOP: if (rx_cyc_r == 11'h000) begin
        rx_st_nxt = RX_IDLE;
        rx_cnt_nxt = 4'h0;
        if (link.d2h) begin
          rx_buf_nxt[rx_cnt_r] = rx_sh_r;
          rx_cnt_nxt = (rx_cnt_r == PKT_LAST) ? 4'h0 : rx_cnt_r + 4'h1;
          pkt_in_nxt = (rx_cnt_r == PKT_LAST);
        end
      end
    endcase
    unique case (tx_st_r)
      TX_IDLE: if (h_st_r == H_SEND) begin
        tx_st_nxt = TX_START;
        tx_cyc_nxt = div - 11'h001;
        tx_sh_nxt = txq_r[tx_idx_r];
        txd_nxt = 1'b0;
      end
      TX_START: if (tx_cyc_r == 11'h000) begin
        tx_st_nxt = TX_DATA;
        tx_cyc_nxt = div - 11'h001;
        tx_bit_nxt = 3'h0;
        txd_nxt = tx_sh_r[0];
      end
      TX_DATA: if (tx_cyc_r == 11'h000) begin
        tx_cyc_nxt = div - 11'h001;
        tx_bit_nxt = tx_bit_r + 3'h1;
        tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
        txd_nxt = tx_sh_r[1];
        if (tx_bit_r == LAST_BIT) begin
          tx_st_nxt = TX_STOP;
          txd_nxt = 1'b1;
        end
      end
      TX_STOP: if (tx_cyc_r == 11'h000) begin
        tx_st_nxt = TX_IDLE;
        tx_idx_nxt = tx_idx_r + 4'h1;
        if (tx_idx_r == PKT_LAST) begin
          tx_idx_nxt = 4'h0;
          h_st_nxt = H_WAIT;
          tmo_nxt = 32'(RSP_TIMEOUT_CYC);
        end
      end
    endcase
    unique case (h_st_r)
      // one command outstanding at a time
      H_IDLE: if (cmd_valid) begin
        txq_nxt = {8'h00, cmd_data, cmd_sub, cmd_index, cmd_code, cmd_station};
        txq_nxt[9] = pkt_csum(txq_nxt);
        stn_nxt = cmd_station;
        skip_nxt = chain_mode;
        rdy_nxt = 1'b0;
        tmo_err_nxt = 1'b0;
        h_st_nxt = H_SEND;
      end
      H_SEND: ;
      H_WAIT: begin
        tmo_nxt = tmo_r - 32'h00000001;
        if (pkt_in_r && skip_r) begin
          // first packet back is the echoed command
          skip_nxt = 1'b0;
        end else if (good) begin
          // reply code and data returned as received
          code_nxt = rx_buf_r[1];
          data_nxt = {rx_buf_r[8], rx_buf_r[7], rx_buf_r[6], rx_buf_r[5]};
          vld_nxt = 1'b1;
          rdy_nxt = 1'b1;
          h_st_nxt = H_IDLE;
        end else if (tmo_r == 32'h00000000) begin
          // give up rather than wait forever
          tmo_err_nxt = 1'b1;
          vld_nxt = 1'b1;
          rdy_nxt = 1'b1;
          h_st_nxt = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      h_st_r <= H_IDLE;
      rx_st_r <= RX_IDLE;
      rx_cyc_r <= 11'h000;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_buf_r <= '0;
      rx_cnt_r <= 4'h0;
      pkt_in_r <= 1'b0;
      tx_st_r <= TX_IDLE;
      tx_cyc_r <= 11'h000;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      txq_r <= '0;
      tx_idx_r <= 4'h0;
      txd_r <= 1'b1;
      skip_r <= 1'b0;
      stn_r <= 8'h00;
      tmo_r <= 32'h00000000;
      rdy_r <= 1'b1;
      vld_r <= 1'b0;
      tmo_err_r <= 1'b0;
      code_r <= 8'h00;
      data_r <= 32'h00000000;
    end else begin
      h_st_r <= h_st_nxt;
      rx_st_r <= rx_st_nxt;
      rx_cyc_r <= rx_cyc_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_buf_r <= rx_buf_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      pkt_in_r <= pkt_in_nxt;
      tx_st_r <= tx_st_nxt;
      tx_cyc_r <= tx_cyc_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      txq_r <= txq_nxt;
      tx_idx_r <= tx_idx_nxt;
      txd_r <= txd_nxt;
      skip_r <= skip_nxt;
      stn_r <= stn_nxt;
      tmo_r <= tmo_nxt;
      rdy_r <= rdy_nxt;
      vld_r <= vld_nxt;
      tmo_err_r <= tmo_err_nxt;
      code_r <= code_nxt;
      data_r <= data_nxt;
    end
  end

  assign link.h2d = txd_r;
  assign cmd_ready = rdy_r;
  assign rsp_valid = vld_r;
  assign rsp_code = code_r;
  assign rsp_data = data_r;
  assign rsp_timeout = tmo_err_r;
endmodule

// ### bench/ssc_link_asserts.sv
`timescale 1ns/1ps
module ssc_link_asserts #(
  parameter int BIT_CYC = 651
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic h2d,
  input wire logic d2h
);
  localparam int GAP = 12 * BIT_CYC;
  logic [1:0] ln;
  logic [1:0] prev_r;
  logic [1:0] prev_nxt;
  logic [1:0][13:0] run_r;
  logic [1:0][13:0] run_nxt;
  logic [1:0][4:0] cnt_r;
  logic [1:0][4:0] cnt_nxt;
  logic [1:0][13:0] chr_r;
  logic [1:0][13:0] chr_nxt;
  localparam int CHR = 19 * BIT_CYC / 2;
  assign ln = {d2h, h2d};
  // Runs saturate at the gap, so a packet boundary is an idle of twelve bit times
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      prev_nxt[i] = ln[i];
      run_nxt[i] = (ln[i] != prev_r[i]) ? 14'h0001 :
                   (run_r[i] == 14'(GAP)) ? run_r[i] : run_r[i] + 14'h0001;
      // Data bits fall too, so only a fall outside a character counts as a start bit
      chr_nxt[i] = (chr_r[i] != 14'h0000) ? chr_r[i] - 14'h0001 :
                   (prev_r[i] && !ln[i]) ? 14'(CHR) : 14'h0000;
      cnt_nxt[i] = (prev_r[i] && !ln[i] && chr_r[i] == 14'h0000) ? cnt_r[i] + 5'h01 :
                   (ln[i] && run_r[i] == 14'(GAP)) ? 5'h00 : cnt_r[i];
    end
  end
  // Reset starts both lines as long idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 2'h3;
      run_r <= {2{14'(GAP)}};
      cnt_r <= '0;
      chr_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      run_r <= run_nxt;
      cnt_r <= cnt_nxt;
      chr_r <= chr_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_H2D_START_LEN: assert property (!prev_r[0] && h2d |-> run_r[0] >= 14'(BIT_CYC))
    else $error("h2d low run shorter than one bit");
  AST_D2H_START_LEN: assert property (!prev_r[1] && d2h |-> run_r[1] >= 14'(BIT_CYC))
    else $error("d2h low run shorter than one bit");
  AST_H2D_STOP_HIGH: assert property (!prev_r[0] && h2d |-> run_r[0] <= 14'(9 * BIT_CYC))
    else $error("h2d low through the stop bit");
  AST_D2H_STOP_HIGH: assert property (!prev_r[1] && d2h |-> run_r[1] <= 14'(9 * BIT_CYC))
    else $error("d2h low through the stop bit");
  AST_H2D_BIT_MIN: assert property (prev_r[0] && !h2d && chr_r[0] == 14'h0000 |-> run_r[0] > 14'(BIT_CYC))
    else $error("h2d high run shorter than stop plus idle");
  AST_D2H_BIT_MIN: assert property (prev_r[1] && !d2h && chr_r[1] == 14'h0000 |-> run_r[1] > 14'(BIT_CYC))
    else $error("d2h high run shorter than stop plus idle");
  AST_H2D_TEN_BYTES: assert property (h2d && run_r[0] == 14'(GAP) |-> cnt_r[0] inside {5'h00, 5'h0A})
    else $error("h2d packet not ten characters");
  AST_D2H_TEN_BYTES: assert property (d2h && run_r[1] == 14'(GAP) |-> cnt_r[1] inside {5'h00, 5'h0A})
    else $error("d2h reply not ten characters");
  AST_D2H_QUIET: assert property (!h2d |-> d2h)
    else $error("d2h active while a command is arriving");
  AST_D2H_HOST_IDLE: assert property ($fell(d2h) |-> h2d [*8])
    else $error("h2d active during a reply character");
  cover property (d2h && run_r[1] == 14'(GAP) && cnt_r[1] == 5'h0A);
  cover property (h2d && run_r[0] == 14'(GAP) && cnt_r[0] == 5'h0A);
  cover property ($fell(d2h));
endmodule

// ### bench/tb_serial_port_config.sv
`timescale 1ns/1ps
module tb_serial_port_config;
  import ssc_pkg::*;
  localparam int TMO = 80000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic restart = 1'b0;
  logic digital_input_one = 1'b0;
  logic digital_input_three = 1'b0;
  logic din_func_assigned = 1'b0;
  logic [15:0] rate_code = RATE_DEF;
  // single drive, chain mode 0 both ends
  logic chain_mode = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_station = 8'h00;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_index = 16'h0000;
  logic [7:0] cmd_sub = 8'h00;
  logic [31:0] cmd_data = 32'h00000000;
  logic [7:0] active_station;
  logic [15:0] active_rate_code;
  logic active_chain, drive_enable, op_mode_sel, pkt_dropped;
  logic cmd_ready, rsp_valid, rsp_timeout;
  logic [7:0] rsp_code;
  logic [31:0] rsp_data;
  int errors = 0;
  int compares = 0;
  logic dropped_seen = 1'b0;
  ssc_link_if link();
  ssc_drive u_ssc_drive (.clk(clk), .rst(rst), .restart(restart), .link(link),
    .digital_input_one(digital_input_one), .digital_input_three(digital_input_three),
    .din_func_assigned(din_func_assigned), .active_station(active_station), .active_rate_code(active_rate_code),
    .active_chain(active_chain), .drive_enable(drive_enable), .op_mode_sel(op_mode_sel),
    .pkt_dropped(pkt_dropped));
  ssc_host #(.RSP_TIMEOUT_CYC(TMO)) u_ssc_host (.clk(clk), .rst(rst), .link(link), .rate_code(rate_code),
    .chain_mode(chain_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_station(cmd_station),
    .cmd_code(cmd_code), .cmd_index(cmd_index), .cmd_sub(cmd_sub), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout));
  ssc_link_asserts #(.BIT_CYC(651)) u_ssc_link_asserts (.clk(clk), .rst(rst), .h2d(link.h2d), .d2h(link.d2h));
  always #20 clk = ~clk;
  // The drop pulse lasts one cycle, so it is latched for the final check
  always @(negedge clk) begin
    if (pkt_dropped !== 1'b0) begin
      dropped_seen <= 1'b1;
    end
  end
  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One command outstanding: the task returns on a reply, on the host's own timeout, or after 200000 cycles of waiting
  task automatic xfer(input logic [7:0] st, input logic [7:0] code, input logic [15:0] idx,
                      input logic [7:0] sub, input logic [31:0] dat);
    int n;
    @(posedge clk);
    cmd_station <= st;
    cmd_code <= code;
    cmd_index <= idx;
    cmd_sub <= sub;
    cmd_data <= dat;
    cmd_valid <= 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 200000) begin
      @(negedge clk);
      n++;
    end
    check("rsp_valid", 32'h1, 32'(rsp_valid));
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    check("active_station", 32'h01, 32'(active_station));
    check("active_rate_code", 32'h010E, 32'(active_rate_code));
    check("active_chain", 32'h0, 32'(active_chain));
    @(posedge clk);
    din_func_assigned <= 1'b1;
    digital_input_one <= 1'b1;
    digital_input_three <= 1'b1;
    repeat (2) @(negedge clk);
    check("drive_enable", 32'h1, 32'(drive_enable));
    check("op_mode_sel", 32'h1, 32'(op_mode_sel));
    @(posedge clk);
    din_func_assigned <= 1'b0;
    repeat (2) @(negedge clk);
    check("drive_enable", 32'h0, 32'(drive_enable));
    check("op_mode_sel", 32'h0, 32'(op_mode_sel));
    xfer(8'h01, 8'h40, 16'h2FE0, 8'h00, 32'h0);
    check("rsp_code", 32'h4B, 32'(rsp_code));
    check("rsp_data", 32'h0000010E, rsp_data);
    check("rsp_timeout", 32'h0, 32'(rsp_timeout));
    xfer(8'h01, 8'h2F, 16'h100B, 8'h00, 32'h05);
    check("rsp_code", 32'h60, 32'(rsp_code));
    check("rsp_data", 32'h05, rsp_data);
    // Restart without a save keeps the old station
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    repeat (3) @(negedge clk);
    check("active_station", 32'h01, 32'(active_station));
    // Save then restart applies the new station
    xfer(8'h01, 8'h2F, 16'h2FF0, 8'h01, 32'h01);
    check("rsp_code", 32'h60, 32'(rsp_code));
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    repeat (3) @(negedge clk);
    check("active_station", 32'h05, 32'(active_station));
    check("active_rate_code", 32'h010E, 32'(active_rate_code));
    xfer(8'h07, 8'h40, 16'h100B, 8'h00, 32'h0);
    check("rsp_timeout", 32'h1, 32'(rsp_timeout));
    check("pkt_dropped", 32'h0, 32'(dropped_seen));
    print_verdict();
  end
  initial begin
    repeat (650000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule
